//--- common/swt_pkg.sv
/*
 * Constants for the sleep/wake timer with wake tally.
 * Assumes byte-wide register access at the offsets below.
 */
package swt_pkg;

    // Register offsets
    localparam logic [9:0] SWT_EVENT_MASK_LOW     = 10'h100;
    localparam logic [9:0] SWT_WAKE_TALLY_A       = 10'h102;
    localparam logic [9:0] SWT_WAKE_TALLY_B       = 10'h103;
    localparam logic [9:0] SWT_WAKE_LIMIT_A       = 10'h104;
    localparam logic [9:0] SWT_WAKE_LIMIT_B       = 10'h105;
    localparam logic [9:0] SWT_WAKE_CONFIG_HIGH   = 10'h30c;
    localparam logic [9:0] SWT_WAKE_CONFIG_LOW    = 10'h30d;
    localparam logic [9:0] SWT_WAKE_INTERVAL_HIGH = 10'h30e;
    localparam logic [9:0] SWT_WAKE_INTERVAL_LOW  = 10'h30f;

    // Field positions
    localparam int SWT_DIV_SEL_LSB    = 0;
    localparam int SWT_TRIM_LSB       = 3;
    localparam int SWT_RC_EN_BIT      = 6;
    localparam int SWT_XTAL_EN_BIT    = 5;
    localparam int SWT_SRC_SEL_BIT    = 4;
    localparam int SWT_RETAIN_BIT     = 3;
    localparam int SWT_ARM_BIT        = 0;
    localparam int SWT_TALLY_MASK_BIT = 0;

    // Reset values
    localparam logic [7:0]  SWT_BYTE_RESET  = 8'h00;
    localparam logic [15:0] SWT_WORD_RESET  = 16'h0000;
    localparam logic [7:0]  SWT_READ_ZERO   = 8'h00;

    // Timing
    localparam int SWT_SRC_FREQ_HZ = 32768;

    typedef enum logic [1:0] {
        SWT_ST_ACTIVE,
        SWT_ST_SLEEP,
        SWT_ST_WAKE,
        SWT_ST_OFF
    } swt_state_e;

    // Terminal count of the prescaler (divider minus one)
    function automatic logic [15:0] swt_div_last(input logic [2:0] sel);
        logic [15:0] r;
        r = 16'h0000;
        unique case (sel)
            3'h0: r = 16'h0000;
            3'h1: r = 16'h0003;
            3'h2: r = 16'h0007;
            3'h3: r = 16'h000f;
            3'h4: r = 16'h007f;
            3'h5: r = 16'h03ff;
            3'h6: r = 16'h1fff;
            3'h7: r = 16'hffff;
        endcase
        return r;
    endfunction : swt_div_last

endpackage : swt_pkg

//--- dv/swt_host.sv
/* Host processor model on the register port.
   Drives at the falling edge of sys_clk; strobes last one cycle. */
`timescale 1ns/10ps
module swt_host
    import swt_pkg::*;
(
    // Clock
    input wire logic       sys_clk,
    // Register port
    output logic     [9:0] reg_addr,
    output logic     [7:0] reg_wdata,
    output logic           reg_wr,
    output logic           reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid
);
    initial
    begin
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Idle bus shows inverted values, never the stale ones
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    task rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask : rd

    task wr16(input logic [9:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 10'h001, v[7:0]);
    endtask : wr16

    task rd16(input logic [9:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 10'h001, v[7:0]);
    endtask : rd16

    // Clear, unmask, config pair, interval pair; reserved bits zero
    task setup(input logic [15:0] cfg, input logic [15:0] ivl,
               input logic [7:0] mask);
        wr(SWT_EVENT_MASK_LOW, 8'h00);
        wr(SWT_EVENT_MASK_LOW, mask);
        wr16(SWT_WAKE_CONFIG_HIGH, cfg & 16'h7f79);
        wr16(SWT_WAKE_INTERVAL_HIGH, ivl);
    endtask : setup
endmodule : swt_host

//--- dv/swt_sva.sv
/* Port checker for the sleep/wake timer.
   Bound to swt_top; sees only its ports, all in the sys_clk domain. */
`timescale 1ns/10ps
module swt_sva
    import swt_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    // Commands and status
    input wire logic       sleep_cmd,
    input wire logic       cal_request,
    input wire logic       host_irq_pin,
    input wire logic       fine_cal_start,
    input wire logic       in_sleep_state,
    input wire logic       in_off_state,
    input wire logic       retention_power_on
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire wo_rd = reg_rd && (reg_addr >= SWT_WAKE_CONFIG_HIGH)
                 && (reg_addr <= SWT_WAKE_INTERVAL_LOW);

    property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
    property p_rv_cause; reg_rvalid |-> $past(reg_rd); endproperty
    property p_wo_read; wo_rd |=> reg_rdata == SWT_READ_ZERO; endproperty
    property p_cal; cal_request |=> fine_cal_start; endproperty
    property p_wake_cal; $fell(in_sleep_state) |-> fine_cal_start; endproperty
    property p_wake_end;
        $fell(in_sleep_state) |=> in_sleep_state != in_off_state;
    endproperty
    property p_irq_off; $rose(host_irq_pin) |-> in_off_state; endproperty
    property p_off_exit;
        sleep_cmd && in_off_state |=> in_sleep_state && !host_irq_pin;
    endproperty
    property p_retain; !in_sleep_state |-> retention_power_on; endproperty

    a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
    a_rv_cause: assert property (p_rv_cause) else $error("stray read");
    a_wo_read: assert property (p_wo_read) else $error("config read");
    a_cal: assert property (p_cal) else $error("cal not started");
    a_wake_cal: assert property (p_wake_cal) else $error("no wake cal");
    a_wake_end: assert property (p_wake_end) else $error("wake end");
    a_irq_off: assert property (p_irq_off) else $error("irq not off");
    a_off_exit: assert property (p_off_exit) else $error("off exit");
    a_retain: assert property (p_retain) else $error("ram unpowered");

    c_wake: cover property ($fell(in_sleep_state));
    c_irq: cover property ($rose(host_irq_pin));
    c_wo: cover property (wo_rd);
endmodule : swt_sva

bind swt_top swt_sva u_swt_sva (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sleep_cmd(sleep_cmd),
    .cal_request(cal_request), .host_irq_pin(host_irq_pin),
    .fine_cal_start(fine_cal_start), .in_sleep_state(in_sleep_state),
    .in_off_state(in_off_state), .retention_power_on(retention_power_on));

//--- dv/tb.sv
/* Self-checking bench for swt_top with a host model.
   Tick clock 125 ns free running, system clock 20 ns. */
`timescale 1ns/10ps
module tb;
    import swt_pkg::*;
    logic sys_clk, rstn, tick_clk, sleep_cmd, cal_request, reg_wr, reg_rd;
    logic       reg_rvalid, host_irq_pin, fine_cal_start, in_sleep_state;
    logic       in_off_state, retention_power_on, rc_source_enable;
    logic       crystal_source_enable, tick_source_select;
    logic [3:0] rc_coarse_trim;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [15:0] v;
    int fails, total_checks, n;

    swt_top u_swt_top (.sys_clk(sys_clk), .rstn(rstn), .tick_clk(tick_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sleep_cmd(sleep_cmd), .cal_request(cal_request),
        .host_irq_pin(host_irq_pin), .fine_cal_start(fine_cal_start),
        .in_sleep_state(in_sleep_state), .in_off_state(in_off_state),
        .retention_power_on(retention_power_on),
        .rc_source_enable(rc_source_enable),
        .crystal_source_enable(crystal_source_enable),
        .tick_source_select(tick_source_select),
        .rc_coarse_trim(rc_coarse_trim));
    swt_host u_swt_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        tick_clk = 1'b0;
        #37;
        forever #62.5 tick_clk = ~tick_clk;
    end

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task test_done;
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    task pulse_sleep;
        @(negedge sys_clk);
        sleep_cmd = 1'b1;
        @(negedge sys_clk);
        sleep_cmd = 1'b0;
    endtask : pulse_sleep

    // Counts cycles spent asleep, bounded
    task wait_wake;
        n = 0;
        while (in_sleep_state === 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
    endtask : wait_wake

    task t_regs;
        u_swt_host.wr16(SWT_WAKE_LIMIT_A, 16'ha55a);
        u_swt_host.rd16(SWT_WAKE_LIMIT_A, v);
        chk("limit", 16'ha55a, v);
        u_swt_host.wr16(SWT_WAKE_TALLY_A, 16'h0102);
        u_swt_host.rd16(SWT_WAKE_TALLY_A, v);
        chk("tally", 16'h0102, v);
        u_swt_host.rd(10'h200, d);
        chk("unmapped", 16'h0000, {8'h00, d});
    endtask : t_regs

    task t_wake;
        u_swt_host.wr16(SWT_WAKE_LIMIT_A, 16'h0001);
        u_swt_host.wr16(SWT_WAKE_TALLY_A, 16'h0000);
        u_swt_host.setup(16'h6959, 16'h0003, 8'h01);
        chk("cfg_out", 16'h006d, {9'h000, rc_coarse_trim, rc_source_enable,
            crystal_source_enable, tick_source_select});
        for (int i = 0; i < 4; i++)
        begin
            u_swt_host.rd(SWT_WAKE_CONFIG_HIGH + 10'(i), d);
            chk("write_only", 16'h0000, {8'h00, d});
        end
        pulse_sleep();
        chk("retained", 16'h0003, {in_sleep_state, retention_power_on});
        wait_wake();
        chk("back_asleep", 16'h0002, {in_sleep_state, in_off_state});
        u_swt_host.rd16(SWT_WAKE_TALLY_A, v);
        chk("tally_inc", 16'h0001, v);
        wait_wake();
        // 3 counts of 4 ticks at 125 ns is 75 system cycles
        chk("period", 16'h0001, {15'h0, n inside {[70:78]}});
        chk("off_irq", 16'h0003, {in_off_state, host_irq_pin});
        u_swt_host.rd16(SWT_WAKE_TALLY_A, v);
        chk("tally_clr", 16'h0000, v);
        // Same trim and sources, retention bit cleared
        u_swt_host.setup(16'h6951, 16'h0003, 8'h00);
        pulse_sleep();
        chk("unretained", 16'h0000, {host_irq_pin, retention_power_on});
        wait_wake();
        wait_wake();
        chk("masked", 16'h0002, {in_sleep_state, host_irq_pin});
        u_swt_host.rd16(SWT_WAKE_TALLY_A, v);
        chk("tally_clr2", 16'h0000, v);
    endtask : t_wake

    // Crystal source, divider 8; third wake is one full period after the
    // second whatever the old timer did during the reload
    task t_div;
        u_swt_host.setup(16'h6a29, 16'h0002, 8'h00);
        chk("xtal_cfg", 16'h006a, {9'h000, rc_coarse_trim, rc_source_enable,
            crystal_source_enable, tick_source_select});
        wait_wake();
        wait_wake();
        wait_wake();
        // 2 counts of 8 ticks is 100 cycles, less one for wait_wake's lag
        chk("period8", 16'h0063, n[15:0]);
    endtask : t_div

    task t_cal;
        @(negedge sys_clk);
        cal_request = 1'b1;
        @(negedge sys_clk);
        cal_request = 1'b0;
        chk("cal", 16'h0001, {15'h0, fine_cal_start});
    endtask : t_cal

    initial
    begin
        fails = 0;
        total_checks = 0;
        rstn = 1'b0;
        sleep_cmd = 1'b0;
        cal_request = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("reset", 16'h0001, {in_sleep_state, host_irq_pin,
            retention_power_on});
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_regs();
        t_wake();
        t_div();
        t_cal();
        test_done();
    end

    initial
    begin
        #60000;
        fails++;
        test_done();
    end
endmodule : tb

//--- hw/swt_top.sv
/*
 * Sleep/wake timer: prescaled 16-bit down counter on the tick clock,
 * wake sequencing and wake tally on the system clock.
 * Assumes tick_clk is the selected 32.768 kHz source running free, and
 * that register accesses come from logic on sys_clk.
 */
// What this block does
// - The four wake controller configuration registers are write-only.
// - After both interval bytes, timer counts from the 16-bit value.
// - Interval equals count times divider over 32.768 kHz.
// - Divider select picks 1,4,8,16,128,1024,8192,65536.
// - Four-bit RC coarse trim selects one of sixteen tuning states.
// - Low config bits enable RC, crystal, and select tick source.
// - Retention bit keeps retention RAM powered during sleep.
// - Arm bit enables wake from sleep on timer timeout.
// - Device wakes from sleep at each timer expiry.
// - Host-writable 16-bit tally limit across two bytes.
// - Every wake increments the 16-bit wake tally.
// - Tally above limit is cleared to zero.
// - Above limit with mask set: raise host interrupt, enter off.
// - Fine RC calibration runs on every wake and cold start.
// - Host may request a fine RC calibration at any time.
// - 16-bit down counter clocked through 16-bit prescaler with 3-bit divider select.
// - Tally at or below limit returns to sleep, not off.
`timescale 1ns/10ps
module swt_top
    import swt_pkg::*;
(
    // Clocks and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       tick_clk,
    // Register access
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    // Commands
    input  wire logic       sleep_cmd,
    input  wire logic       cal_request,
    // Status and control outputs
    output logic            host_irq_pin,
    output logic            fine_cal_start,
    output logic            in_sleep_state,
    output logic            in_off_state,
    output logic            retention_power_on,
    output logic            rc_source_enable,
    output logic            crystal_source_enable,
    output logic            tick_source_select,
    output logic      [3:0] rc_coarse_trim
);

    // Reset synchronisers
    logic [1:0] sys_rst_pipe;
    logic [1:0] tk_rst_pipe;
    wire        sys_rstn = sys_rst_pipe[1];
    wire        tk_rstn  = tk_rst_pipe[1];

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sys_rst_pipe <= 2'h0;
        else
            sys_rst_pipe <= {sys_rst_pipe[0], 1'b1};
    end

    always_ff @(posedge tick_clk or negedge rstn)
    begin
        if (!rstn)
            tk_rst_pipe <= 2'h0;
        else
            tk_rst_pipe <= {tk_rst_pipe[0], 1'b1};
    end

    // System-domain registers
    logic [7:0]  mask_reg;
    logic [15:0] tally_reg;
    logic [15:0] limit_reg;
    logic [7:0]  cfg_hi_hold_reg;
    logic [7:0]  cfg_hi_reg;
    logic [7:0]  cfg_lo_reg;
    logic [7:0]  ivl_hi_hold_reg;
    logic [18:0] load_word_reg;
    logic        load_tgl_reg;
    swt_state_e  state_reg;
    swt_state_e  state_next;
    logic        cold_cal_reg;

    // Address decode
    wire wr_mask   = reg_wr && (reg_addr == SWT_EVENT_MASK_LOW);
    wire wr_tal_a  = reg_wr && (reg_addr == SWT_WAKE_TALLY_A);
    wire wr_tal_b  = reg_wr && (reg_addr == SWT_WAKE_TALLY_B);
    wire wr_lim_a  = reg_wr && (reg_addr == SWT_WAKE_LIMIT_A);
    wire wr_lim_b  = reg_wr && (reg_addr == SWT_WAKE_LIMIT_B);
    wire wr_cfg_hi = reg_wr && (reg_addr == SWT_WAKE_CONFIG_HIGH);
    wire wr_cfg_lo = reg_wr && (reg_addr == SWT_WAKE_CONFIG_LOW);
    wire wr_ivl_hi = reg_wr && (reg_addr == SWT_WAKE_INTERVAL_HIGH);
    wire wr_ivl_lo = reg_wr && (reg_addr == SWT_WAKE_INTERVAL_LOW);

    // Read mux; config and interval registers read as zero
    logic [7:0] rd_mux;
    assign rd_mux =
        (reg_addr == SWT_EVENT_MASK_LOW) ? mask_reg :
        (reg_addr == SWT_WAKE_TALLY_A)   ? tally_reg[15:8] :
        (reg_addr == SWT_WAKE_TALLY_B)   ? tally_reg[7:0] :
        (reg_addr == SWT_WAKE_LIMIT_A)   ? limit_reg[15:8] :
        (reg_addr == SWT_WAKE_LIMIT_B)   ? limit_reg[7:0] :
                                           SWT_READ_ZERO;

    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
        begin
            reg_rdata  <= SWT_BYTE_RESET;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rdata  <= reg_rd ? rd_mux : SWT_BYTE_RESET;
            reg_rvalid <= reg_rd;
        end
    end

    // Config fields
    wire [2:0] div_sel  = cfg_hi_reg[SWT_DIV_SEL_LSB +: 3];
    wire       arm      = cfg_lo_reg[SWT_ARM_BIT];
    wire       retain   = cfg_lo_reg[SWT_RETAIN_BIT];
    wire       src_sel  = cfg_lo_reg[SWT_SRC_SEL_BIT];
    wire       src_on   = src_sel ? cfg_lo_reg[SWT_RC_EN_BIT]
                                  : cfg_lo_reg[SWT_XTAL_EN_BIT];

    // Config pair: high byte held, both applied on low byte
    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
        begin
            mask_reg        <= SWT_BYTE_RESET;
            limit_reg       <= SWT_WORD_RESET;
            cfg_hi_hold_reg <= SWT_BYTE_RESET;
            cfg_hi_reg      <= SWT_BYTE_RESET;
            cfg_lo_reg      <= SWT_BYTE_RESET;
            ivl_hi_hold_reg <= SWT_BYTE_RESET;
        end
        else
        begin
            if (wr_mask)
                mask_reg <= reg_wdata;
            if (wr_lim_a)
                limit_reg[15:8] <= reg_wdata;
            if (wr_lim_b)
                limit_reg[7:0] <= reg_wdata;
            if (wr_cfg_hi)
                cfg_hi_hold_reg <= reg_wdata;
            if (wr_cfg_lo)
            begin
                cfg_hi_reg <= cfg_hi_hold_reg;
                cfg_lo_reg <= reg_wdata;
            end
            if (wr_ivl_hi)
                ivl_hi_hold_reg <= reg_wdata;
        end
    end

    // Interval word and divider handed to the tick domain by toggle
    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
        begin
            load_word_reg <= {3'h0, SWT_WORD_RESET};
            load_tgl_reg  <= 1'b0;
        end
        else if (wr_ivl_lo)
        begin
            load_word_reg <= {div_sel, ivl_hi_hold_reg, reg_wdata};
            load_tgl_reg  <= ~load_tgl_reg;
        end
    end

    // Tick domain: crossings in
    logic [1:0]  tk_load_sync;
    logic        tk_load_seen;
    logic [1:0]  tk_run_sync;
    logic [15:0] tk_ivl;
    logic [2:0]  tk_div;
    logic        tk_loaded;
    logic [15:0] tk_presc;
    logic [15:0] tk_count;
    logic        tk_tmo_tgl;

    wire tk_load = tk_load_sync[1] ^ tk_load_seen;
    wire tk_tick = tk_run_sync[1] && tk_loaded &&
                   (tk_presc == swt_div_last(tk_div));
    wire tk_zero = (tk_count <= 16'h0001);

    always_ff @(posedge tick_clk or negedge tk_rstn)
    begin
        if (!tk_rstn)
        begin
            tk_load_sync <= 2'h0;
            tk_load_seen <= 1'b0;
            tk_run_sync  <= 2'h0;
        end
        else
        begin
            tk_load_sync <= {tk_load_sync[0], load_tgl_reg};
            tk_load_seen <= tk_load_sync[1];
            tk_run_sync  <= {tk_run_sync[0], src_on};
        end
    end

    // Prescaler and down counter
    always_ff @(posedge tick_clk or negedge tk_rstn)
    begin
        if (!tk_rstn)
        begin
            tk_ivl     <= SWT_WORD_RESET;
            tk_div     <= 3'h0;
            tk_loaded  <= 1'b0;
            tk_presc   <= SWT_WORD_RESET;
            tk_count   <= SWT_WORD_RESET;
            tk_tmo_tgl <= 1'b0;
        end
        else if (tk_load)
        begin
            tk_ivl    <= load_word_reg[15:0];
            tk_div    <= load_word_reg[18:16];
            tk_count  <= load_word_reg[15:0];
            tk_presc  <= SWT_WORD_RESET;
            tk_loaded <= 1'b1;
        end
        else if (tk_run_sync[1] && tk_loaded)
        begin
            tk_presc <= tk_tick ? SWT_WORD_RESET
                                : tk_presc + 16'h0001;
            if (tk_tick)
            begin
                if (tk_zero)
                begin
                    tk_count   <= tk_ivl;
                    tk_tmo_tgl <= ~tk_tmo_tgl;
                end
                else
                    tk_count <= tk_count - 16'h0001;
            end
        end
    end

    // Timeout event back to the system domain
    logic [2:0] tmo_sync;
    wire        timeout = tmo_sync[2] ^ tmo_sync[1];

    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
            tmo_sync <= 3'h0;
        else
            tmo_sync <= {tmo_sync[1:0], tk_tmo_tgl};
    end

    // Wake sequencing
    wire [15:0] tally_inc  = tally_reg + 16'h0001;
    wire        over_limit = (tally_inc > limit_reg);
    wire        irq_en     = mask_reg[SWT_TALLY_MASK_BIT];
    wire        in_wake    = (state_reg == SWT_ST_WAKE);
    wire        irq_set    = in_wake && over_limit && irq_en;
    wire        irq_clr    = wr_mask || sleep_cmd;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            SWT_ST_ACTIVE,
            SWT_ST_OFF:
                if (sleep_cmd)
                    state_next = SWT_ST_SLEEP;
            SWT_ST_SLEEP:
                if (timeout && arm)
                    state_next = SWT_ST_WAKE;
            SWT_ST_WAKE:
                state_next = irq_set ? SWT_ST_OFF
                                     : SWT_ST_SLEEP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
        begin
            state_reg    <= SWT_ST_ACTIVE;
            cold_cal_reg <= 1'b1;
        end
        else
        begin
            state_reg    <= state_next;
            cold_cal_reg <= 1'b0;
        end
    end

    // Tally; the hardware update wins over a host write
    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
            tally_reg <= SWT_WORD_RESET;
        else if (in_wake)
            tally_reg <= over_limit ? SWT_WORD_RESET : tally_inc;
        else
        begin
            if (wr_tal_a)
                tally_reg[15:8] <= reg_wdata;
            if (wr_tal_b)
                tally_reg[7:0] <= reg_wdata;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk or negedge sys_rstn)
    begin
        if (!sys_rstn)
        begin
            host_irq_pin          <= 1'b0;
            fine_cal_start        <= 1'b0;
            in_sleep_state        <= 1'b0;
            in_off_state          <= 1'b0;
            retention_power_on    <= 1'b1;
            rc_source_enable      <= 1'b0;
            crystal_source_enable <= 1'b0;
            tick_source_select    <= 1'b0;
            rc_coarse_trim        <= 4'h0;
        end
        else
        begin
            host_irq_pin   <= irq_set || (host_irq_pin && !irq_clr);
            fine_cal_start <= cold_cal_reg || cal_request ||
                              (state_next == SWT_ST_WAKE &&
                               state_reg == SWT_ST_SLEEP);
            in_sleep_state <= (state_next == SWT_ST_SLEEP);
            in_off_state   <= (state_next == SWT_ST_OFF);
            retention_power_on <= (state_next != SWT_ST_SLEEP) ||
                                  retain;
            rc_source_enable      <= cfg_lo_reg[SWT_RC_EN_BIT];
            crystal_source_enable <= cfg_lo_reg[SWT_XTAL_EN_BIT];
            tick_source_select    <= src_sel;
            rc_coarse_trim <= cfg_hi_reg[SWT_TRIM_LSB +: 4];
        end
    end

endmodule : swt_top
